// ==== verilog/iatc_defines.svh ====
// Constants for the image acquisition trigger control block
// Assumes inclusion by bare name; definitions only
`ifndef IATC_DEFINES_SVH
`define IATC_DEFINES_SVH
`define IATC_ADDR_W       4
`define IATC_DATA_W       32
`define IATC_REG_CTRL     4'h0
`define IATC_REG_CMD      4'h1
`define IATC_REG_TRIG     4'h2
`define IATC_REG_FCOUNT   4'h3
`define IATC_REG_EXPO     4'h4
`define IATC_REG_PERIOD   4'h5
`define IATC_REG_STATUS   4'h6
`define IATC_CTRL_SCHEME  0
`define IATC_CTRL_CONT    1
`define IATC_CTRL_PULSEW  2
`define IATC_CMD_ARM      0
`define IATC_CMD_DISARM   1
`define IATC_CMD_SWTRIG   2
`define IATC_TRIG_TARGET  0
`define IATC_TRIG_ON      1
`define IATC_TRIG_LINE    2
`define IATC_TRIG_RISE    3
`define IATC_FCOUNT_RST   32'h0000_0001
`define IATC_EXPO_RST     32'h0000_0028
`define IATC_PERIOD_RST   32'h0000_1000
`define IATC_READOUT_CYC  32'h0000_0010
`endif

// ==== verilog/iatc_pkg.sv ====
// Types for the image acquisition trigger control block
// Assumes iatc_defines.svh on the include path
`default_nettype none
package iatc_pkg;
   typedef enum logic [2:0] {
      IATC_IDLE, IATC_WAIT_ARM, IATC_WAIT_FRAME, IATC_EXPOSE, IATC_READOUT
   } iatc_state_type;
   typedef struct packed {
      logic       target;
      logic       mode_on;
      logic       from_line;
      logic       rising;
   } iatc_trig_cfg_type;
endpackage
`default_nettype wire

// ==== verilog/iatc_core.sv ====
// Acquisition sequencer: arm/disarm, run policy, arming and frame triggers,
// exposure timing by preset or by pulse width. Register port on clk_sys;
// line 1 is asynchronous and synchronised here.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "iatc_defines.svh"
module iatc_core
   import iatc_pkg::*;
(
   input  wire logic                    clk_sys,
   input  wire logic                    sys_rst,
   input  wire logic [`IATC_ADDR_W-1:0] reg_addr,
   input  wire logic [`IATC_DATA_W-1:0] reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [`IATC_DATA_W-1:0] reg_rdata,
   input  wire logic                    line1_in,
   output logic                         exposure_active,
   output logic                         frame_start
);
   ////////////////////////////////////////////////////////////////////////
   // Configuration
   logic                    scheme_current;
   logic                    run_cont;
   logic                    pulse_width_expo;
   logic                    target_frame;
   iatc_trig_cfg_type       arm_cfg;
   iatc_trig_cfg_type       frm_cfg;
   logic [`IATC_DATA_W-1:0] frames_per_arm;
   logic [`IATC_DATA_W-1:0] expo_cycles;
   logic [`IATC_DATA_W-1:0] period_cycles;
   logic                    wr_ctrl;
   logic                    wr_cmd;
   logic                    wr_trig;
   assign wr_ctrl = reg_wr && reg_addr == `IATC_REG_CTRL;
   assign wr_cmd  = reg_wr && reg_addr == `IATC_REG_CMD;
   assign wr_trig = reg_wr && reg_addr == `IATC_REG_TRIG;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         scheme_current   <= 1'b0;
         run_cont         <= 1'b0;
         pulse_width_expo <= 1'b0;
         frames_per_arm   <= `IATC_FCOUNT_RST;
         expo_cycles      <= `IATC_EXPO_RST;
         period_cycles    <= `IATC_PERIOD_RST;
      end else if (reg_wr) begin
         if (wr_ctrl) begin
            scheme_current   <= reg_wdata[`IATC_CTRL_SCHEME];
            run_cont         <= reg_wdata[`IATC_CTRL_CONT];
            pulse_width_expo <= reg_wdata[`IATC_CTRL_PULSEW];
         end
         if (reg_addr == `IATC_REG_FCOUNT)
            frames_per_arm <= reg_wdata;
         if (reg_addr == `IATC_REG_EXPO)
            expo_cycles <= reg_wdata;
         if (reg_addr == `IATC_REG_PERIOD)
            period_cycles <= reg_wdata;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         target_frame <= 1'b1;
         arm_cfg      <= '0;
         frm_cfg      <= '0;
      end else if (wr_trig) begin
         target_frame <= reg_wdata[`IATC_TRIG_TARGET];
         if (reg_wdata[`IATC_TRIG_TARGET]) begin
            frm_cfg.mode_on   <= reg_wdata[`IATC_TRIG_ON];
            frm_cfg.from_line <= reg_wdata[`IATC_TRIG_LINE];
            frm_cfg.rising    <= reg_wdata[`IATC_TRIG_RISE];
         end else begin
            arm_cfg.mode_on   <= reg_wdata[`IATC_TRIG_ON];
            arm_cfg.from_line <= reg_wdata[`IATC_TRIG_LINE];
            arm_cfg.rising    <= reg_wdata[`IATC_TRIG_RISE];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Line 1 synchroniser and edges
   logic line_meta;
   logic line_sync;
   logic line_prev;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         line_meta <= 1'b0;
         line_sync <= 1'b0;
         line_prev <= 1'b0;
      end else begin
         line_meta <= line1_in;
         line_sync <= line_meta;
         line_prev <= line_sync;
      end
   end
   logic line_rise;
   logic line_fall;
   assign line_rise = line_sync && !line_prev;
   assign line_fall = !line_sync && line_prev;

   ////////////////////////////////////////////////////////////////////////
   // Trigger events
   logic sw_pulse;
   logic sw_arm;
   logic sw_frame;
   logic hw_arm;
   logic hw_frame;
   logic hw_frame_end;
   logic int_frame;
   logic arm_stage;
   logic arm_evt;
   logic frame_evt;
   logic frame_from_line;
   assign sw_pulse     = wr_cmd && reg_wdata[`IATC_CMD_SWTRIG];
   assign sw_arm       = sw_pulse && !target_frame;
   assign sw_frame     = sw_pulse && target_frame;
   assign hw_arm       = arm_cfg.rising ? line_rise : line_fall;
   assign hw_frame     = frm_cfg.rising ? line_rise : line_fall;
   assign hw_frame_end = frm_cfg.rising ? line_fall : line_rise;
   assign arm_stage    = scheme_current && arm_cfg.mode_on;
   assign arm_evt      = arm_cfg.from_line ? hw_arm : sw_arm;
   assign frame_from_line = frm_cfg.mode_on && frm_cfg.from_line;
   always_comb begin
      if (!frm_cfg.mode_on)
         frame_evt = int_frame;
      else if (frm_cfg.from_line)
         frame_evt = hw_frame;
      else
         frame_evt = sw_frame;
   end

   logic [`IATC_DATA_W-1:0] period_cnt;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         period_cnt <= '0;
      else if (period_cnt + 32'h1 >= period_cycles)
         period_cnt <= '0;
      else
         period_cnt <= period_cnt + 32'h1;
   end
   assign int_frame = period_cnt == '0;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   iatc_state_type          state;
   logic                    armed;
   logic                    stop_pending;
   logic [`IATC_DATA_W-1:0] frame_cnt;
   logic [`IATC_DATA_W-1:0] phase_cnt;
   logic                    use_width;
   logic                    cmd_arm;
   logic                    cmd_disarm;
   logic                    accept;
   logic                    frame_done;
   logic                    busy;
   assign cmd_arm    = wr_cmd && reg_wdata[`IATC_CMD_ARM];
   assign cmd_disarm = wr_cmd && reg_wdata[`IATC_CMD_DISARM];
   assign busy       = state == IATC_EXPOSE || state == IATC_READOUT;
   assign accept     = state == IATC_WAIT_FRAME && frame_evt && !cmd_disarm;
   assign frame_done = state == IATC_READOUT && phase_cnt + 32'h1 >= `IATC_READOUT_CYC;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state        <= IATC_IDLE;
         armed        <= 1'b0;
         stop_pending <= 1'b0;
         frame_cnt    <= '0;
         phase_cnt    <= '0;
         use_width    <= 1'b0;
      end else begin
         if (cmd_disarm && busy)
            stop_pending <= 1'b1;
         unique case (state)
            IATC_IDLE: begin
               if (cmd_arm) begin
                  armed     <= 1'b1;
                  frame_cnt <= '0;
                  state     <= arm_stage ? IATC_WAIT_ARM : IATC_WAIT_FRAME;
               end
            end
            IATC_WAIT_ARM: begin
               if (cmd_disarm) begin
                  armed <= 1'b0;
                  state <= IATC_IDLE;
               end else if (arm_evt) begin
                  frame_cnt <= '0;
                  state     <= IATC_WAIT_FRAME;
               end
            end
            IATC_WAIT_FRAME: begin
               if (cmd_disarm) begin
                  armed <= 1'b0;
                  state <= IATC_IDLE;
               end else if (accept) begin
                  frame_cnt <= frame_cnt + 32'h1;
                  phase_cnt <= '0;
                  use_width <= frame_from_line && pulse_width_expo;
                  state     <= IATC_EXPOSE;
               end
            end
            IATC_EXPOSE: begin
               phase_cnt <= phase_cnt + 32'h1;
               if (use_width ? hw_frame_end : phase_cnt + 32'h1 >= expo_cycles) begin
                  phase_cnt <= '0;
                  state     <= IATC_READOUT;
               end
            end
            IATC_READOUT: begin
               phase_cnt <= phase_cnt + 32'h1;
               if (frame_done) begin
                  stop_pending <= 1'b0;
                  if (stop_pending || cmd_disarm || !run_cont) begin
                     armed <= 1'b0;
                     state <= IATC_IDLE;
                  end else if (arm_stage && frame_cnt >= frames_per_arm) begin
                     state <= IATC_WAIT_ARM;
                  end else begin
                     state <= IATC_WAIT_FRAME;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         exposure_active <= 1'b0;
         frame_start     <= 1'b0;
      end else begin
         frame_start     <= accept;
         exposure_active <= accept || (state == IATC_EXPOSE &&
                            !(use_width ? hw_frame_end : phase_cnt + 32'h1 >= expo_cycles));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register read
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         reg_rdata <= '0;
      else if (reg_rd) begin
         unique case (reg_addr)
            `IATC_REG_CTRL:   reg_rdata <= {29'h0, pulse_width_expo, run_cont, scheme_current};
            `IATC_REG_TRIG:   reg_rdata <= target_frame ?
                              {28'h0, frm_cfg.rising, frm_cfg.from_line, frm_cfg.mode_on, 1'b1} :
                              {28'h0, arm_cfg.rising, arm_cfg.from_line, arm_cfg.mode_on, 1'b0};
            `IATC_REG_FCOUNT: reg_rdata <= frames_per_arm;
            `IATC_REG_EXPO:   reg_rdata <= expo_cycles;
            `IATC_REG_PERIOD: reg_rdata <= period_cycles;
            `IATC_REG_STATUS: reg_rdata <= {frame_cnt[23:0], 3'h0, stop_pending, armed, state};
            default:          reg_rdata <= '0;
         endcase
      end else
         reg_rdata <= '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_no_frame_unarmed;
      @(posedge clk_sys) disable iff (sys_rst)
         frame_start |-> $past(armed);
   endproperty
   a_no_frame_unarmed: assert property (p_no_frame_unarmed) else $error("Frame while unarmed");

   property p_single_expires;
      @(posedge clk_sys) disable iff (sys_rst)
         (frame_done && !run_cont) |=> state == IATC_IDLE && !armed;
   endproperty
   a_single_expires: assert property (p_single_expires) else $error("Single arm not expired");

   property p_cont_stays;
      @(posedge clk_sys) disable iff (sys_rst)
         (frame_done && run_cont && !stop_pending && !cmd_disarm) |=> armed;
   endproperty
   a_cont_stays: assert property (p_cont_stays) else $error("Continuous arm lost");

   property p_disarm_idle;
      @(posedge clk_sys) disable iff (sys_rst)
         (cmd_disarm && !busy) |=> state == IATC_IDLE;
   endproperty
   a_disarm_idle: assert property (p_disarm_idle) else $error("Disarm not immediate");

   property p_wait_arm_ignores;
      @(posedge clk_sys) disable iff (sys_rst)
         (state == IATC_WAIT_ARM && !arm_evt) |=> state != IATC_EXPOSE;
   endproperty
   a_wait_arm_ignores: assert property (p_wait_arm_ignores) else $error("Frame in wait-arm");

   property p_count_clear;
      @(posedge clk_sys) disable iff (sys_rst)
         (state == IATC_WAIT_ARM && arm_evt && !cmd_disarm) |=>
            state == IATC_WAIT_FRAME && frame_cnt == 0;
   endproperty
   a_count_clear: assert property (p_count_clear) else $error("Count not cleared");

   property p_accept_starts;
      @(posedge clk_sys) disable iff (sys_rst)
         accept && !cmd_disarm |=> frame_start && state == IATC_EXPOSE;
   endproperty
   a_accept_starts: assert property (p_accept_starts) else $error("Frame not started");

   property p_discard;
      @(posedge clk_sys) disable iff (sys_rst)
         (frame_evt && busy) |=> !frame_start;
   endproperty
   a_discard: assert property (p_discard) else $error("Busy trigger taken");

   sequence s_width_expo;
      state == IATC_EXPOSE && use_width && hw_frame_end;
   endsequence
   property p_width_ends;
      @(posedge clk_sys) disable iff (sys_rst)
         s_width_expo |=> state == IATC_READOUT && !exposure_active;
   endproperty
   a_width_ends: assert property (p_width_ends) else $error("Width exposure not ended");

   property p_mid_disarm;
      @(posedge clk_sys) disable iff (sys_rst)
         (cmd_disarm && state == IATC_EXPOSE) |=> state != IATC_IDLE;
   endproperty
   a_mid_disarm: assert property (p_mid_disarm) else $error("Frame cut by disarm");
endmodule
`default_nettype wire

// ==== testbench/iatc_trig_source.sv ====
// External trigger source on input line 1 for the acquisition sequencer
// Assumes the bench calls pulse() and that clk_sys paces the source
`timescale 1ns/100ps
`default_nettype none
module iatc_trig_source (
   input  wire logic clk_sys,
   output var  logic line1_in
);
   initial line1_in = 1'b0;
   // One pulse, active high, the given number of clock cycles wide
   task automatic pulse(input int width);
      @(posedge clk_sys);
      line1_in <= 1'b1;
      repeat (width) @(posedge clk_sys);
      line1_in <= 1'b0;
      repeat (40) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

// ==== testbench/image_acquisition_trigger_control_test.sv ====
// Self-checking bench for iatc_core: register port, software and line triggers
// Assumes iatc_defines.svh on the include path and the trigger source model
`timescale 1ns/100ps
`default_nettype none
`include "iatc_defines.svh"
module image_acquisition_trigger_control_test;
   import iatc_pkg::*;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
   $display("ERROR at %0t got %h expected %h", $time, (a), (b)); end end
   logic                    clk_sys;
   logic                    sys_rst;
   logic [`IATC_ADDR_W-1:0] reg_addr;
   logic [`IATC_DATA_W-1:0] reg_wdata;
   logic                    reg_wr;
   logic                    reg_rd;
   logic [`IATC_DATA_W-1:0] reg_rdata;
   logic                    line1_in;
   logic                    exposure_active;
   logic                    frame_start;
   logic [31:0]             seed;
   int                      n_mismatch, samples_checked, n_frames, expo_run, last_expo;
   int                      cyc, f0, e, w;
   ////////////////////////////////////////////////////////////////////////////////
   iatc_core u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .line1_in(line1_in), .exposure_active(exposure_active), .frame_start(frame_start));
   iatc_trig_source u_src (.clk_sys(clk_sys), .line1_in(line1_in));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Frame and exposure length monitors
   always @(posedge clk_sys) begin
      cyc++;
      if (frame_start === 1'b1) n_frames++;
      if (exposure_active === 1'b1) expo_run++;
      else if (expo_run != 0) begin
         last_expo = expo_run;
         expo_run = 0;
      end
      if (cyc == 30000) begin
         n_mismatch++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic int frame_gap(input int expo);
      return expo + `IATC_READOUT_CYC + 12;
   endfunction
   function automatic int rnd_len();
      seed = lfsr(seed);
      return 4 + int'(seed[3:0]);
   endfunction
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] x);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata & m, x)
   endtask
   // Written twice; the first write already lands on the trigger that its own bit 0 selects
   task automatic sel(input logic [31:0] v);
      wr(`IATC_REG_TRIG, v);
      wr(`IATC_REG_TRIG, v);
   endtask
   task automatic cmd(input logic [31:0] v);
      wr(`IATC_REG_CMD, v);
   endtask
   task automatic final_report();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      seed = 32'hf9253c98;
      repeat (12) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rdc(`IATC_REG_CTRL, 32'hffff_ffff, 32'h0000_0000);
      rdc(`IATC_REG_TRIG, 32'hffff_ffff, 32'h0000_0001);
      rdc(`IATC_REG_FCOUNT, 32'hffff_ffff, `IATC_FCOUNT_RST);
      rdc(`IATC_REG_EXPO, 32'hffff_ffff, `IATC_EXPO_RST);
      rdc(`IATC_REG_PERIOD, 32'hffff_ffff, `IATC_PERIOD_RST);
      rdc(`IATC_REG_STATUS, 32'hffff_ffff, 32'h0000_0000);
      rdc(4'hf, 32'hffff_ffff, 32'h0000_0000);
      $display("test reset_values done");
      e = rnd_len();
      wr(`IATC_REG_EXPO, 32'(e));
      sel(32'h0000_0003);
      f0 = n_frames;
      cmd(32'h0000_0004);
      idle(frame_gap(e));
      `CHK(n_frames, f0)
      cmd(32'h0000_0001);
      rdc(`IATC_REG_STATUS, 32'h0000_0007, 32'h0000_0002);
      cmd(32'h0000_0004);
      idle(frame_gap(e));
      `CHK(n_frames, f0 + 1)
      `CHK(last_expo, e)
      rdc(`IATC_REG_STATUS, 32'h0000_0007, 32'h0000_0000);
      cmd(32'h0000_0004);
      idle(frame_gap(e));
      `CHK(n_frames, f0 + 1)
      $display("test single_frame done");
      wr(`IATC_REG_CTRL, 32'h0000_0002);
      cmd(32'h0000_0001);
      f0 = n_frames;
      for (int i = 0; i < 3; i++) begin
         cmd(32'h0000_0004);
         cmd(32'h0000_0004);
         idle(frame_gap(e));
      end
      `CHK(n_frames, f0 + 3)
      cmd(32'h0000_0002);
      rdc(`IATC_REG_STATUS, 32'h0000_0007, 32'h0000_0000);
      cmd(32'h0000_0004);
      idle(frame_gap(e));
      `CHK(n_frames, f0 + 3)
      cmd(32'h0000_0001);
      cmd(32'h0000_0004);
      cmd(32'h0000_0002);
      idle(frame_gap(e));
      `CHK(last_expo, e)
      `CHK(n_frames, f0 + 4)
      rdc(`IATC_REG_STATUS, 32'h0000_0007, 32'h0000_0000);
      $display("test continuous_disarm done");
      sel(32'h0000_0001);
      wr(`IATC_REG_PERIOD, 32'h0000_0040);
      f0 = n_frames;
      cmd(32'h0000_0001);
      idle(320);
      cmd(32'h0000_0002);
      `CHK(n_frames - f0 >= 4 && n_frames - f0 <= 6, 1'b1)
      idle(80);
      $display("test internal_frames done");
      sel(32'h0000_000f);
      wr(`IATC_REG_CTRL, 32'h0000_0006);
      cmd(32'h0000_0001);
      f0 = n_frames;
      for (int i = 0; i < 3; i++) begin
         w = rnd_len();
         u_src.pulse(w);
         `CHK(last_expo, w)
      end
      `CHK(n_frames, f0 + 3)
      wr(`IATC_REG_CTRL, 32'h0000_0002);
      u_src.pulse(30);
      `CHK(last_expo, e)
      cmd(32'h0000_0002);
      $display("test line_trigger done");
      sel(32'h0000_0002);
      sel(32'h0000_0003);
      cmd(32'h0000_0001);
      rdc(`IATC_REG_STATUS, 32'h0000_0007, 32'h0000_0002);
      cmd(32'h0000_0002);
      wr(`IATC_REG_CTRL, 32'h0000_0003);
      wr(`IATC_REG_FCOUNT, 32'h0000_0002);
      cmd(32'h0000_0001);
      rdc(`IATC_REG_STATUS, 32'h0000_0007, 32'h0000_0001);
      f0 = n_frames;
      cmd(32'h0000_0004);
      idle(frame_gap(e));
      `CHK(n_frames, f0)
      rdc(`IATC_REG_TRIG, 32'hffff_ffff, 32'h0000_0003);
      sel(32'h0000_0002);
      rdc(`IATC_REG_TRIG, 32'hffff_ffff, 32'h0000_0002);
      cmd(32'h0000_0004);
      rdc(`IATC_REG_STATUS, 32'h0000_0007, 32'h0000_0002);
      sel(32'h0000_0003);
      for (int i = 0; i < 2; i++) begin
         cmd(32'h0000_0004);
         idle(frame_gap(e));
      end
      `CHK(n_frames, f0 + 2)
      rdc(`IATC_REG_STATUS, 32'h0000_0007, 32'h0000_0001);
      sel(32'h0000_0002);
      cmd(32'h0000_0004);
      sel(32'h0000_0003);
      cmd(32'h0000_0004);
      idle(frame_gap(e));
      rdc(`IATC_REG_STATUS, 32'hffff_ff07, 32'h0000_0102);
      cmd(32'h0000_0002);
      sel(32'h0000_0000);
      sel(32'h0000_0003);
      cmd(32'h0000_0001);
      rdc(`IATC_REG_STATUS, 32'h0000_0007, 32'h0000_0002);
      cmd(32'h0000_0002);
      $display("test arming_stage done");
      final_report();
   end
endmodule
`default_nettype wire
